// *** hw/nand_cycle_if.sv ***
// Purpose: carries one bus cycle request between sequencer and strobe engine
// Assumes: single clock domain
// Notes:   valid/ready handshake, read byte returned with done
interface nand_cycle_if;
  logic                    valid;
  logic                    ready;
  nand_host_pkg::cyc_t     kind;
  logic [7:0]              wdata;
  logic                    done;
  logic [7:0]              rdata;
  modport seq    (output valid, output kind, output wdata, input ready, input done, input rdata);
  modport engine (input valid, input kind, input wdata, output ready, output done, output rdata);
endinterface

// *** hw/nand_host_pkg.sv ***
// Purpose: shared constants for the nand flash host sequencer
// Assumes: 40 MHz ref_clk, eight-bit multiplexed flash port
// Notes:   command codes, address layout and strobe timing counts
package nand_host_pkg;
  // ==========================================================
  // command codes
  localparam logic [7:0] CMD_READ_SETUP    = 8'h00;
  localparam logic [7:0] CMD_READ_CONFIRM  = 8'h30;
  localparam logic [7:0] CMD_COPY_READ_CNF = 8'h35;
  localparam logic [7:0] CMD_READ_ID       = 8'h90;
  localparam logic [7:0] CMD_RESET         = 8'hFF;
  localparam logic [7:0] CMD_PROG_SETUP    = 8'h80;
  localparam logic [7:0] CMD_PROG_CONFIRM  = 8'h10;
  localparam logic [7:0] CMD_COPY_PROG     = 8'h85;
  localparam logic [7:0] CMD_ERASE_SETUP   = 8'h60;
  localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_RAND_OUT      = 8'h05;
  localparam logic [7:0] CMD_RAND_OUT_CNF  = 8'hE0;
  localparam logic [7:0] CMD_STATUS        = 8'h70;
  localparam logic [7:0] CMD_COPY_STATUS   = 8'h7B;
  // ==========================================================
  // address layout
  localparam int ADDR_BITS   = 29;
  localparam int COL_BITS    = 12;
  localparam int ADDR_CYCLES = 5;
  localparam int ROW_CYCLES  = 3;
  localparam int PAGE_BYTES  = 2112;
  // ==========================================================
  // strobe timing: each phase of a strobe lasts at least this long
  localparam int CLK_PERIOD_PS   = 25000;
  localparam int STROBE_PHASE_NS = 50;
  localparam int STROBE_CYCLES   = (STROBE_PHASE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [3:0] STROBE_LAST = 4'(STROBE_CYCLES - 1);
  // operation kinds requested by the user side
  typedef enum logic [3:0] {
    OP_RESET, OP_STATUS, OP_COPY_STATUS, OP_READ_ID, OP_READ, OP_COPY_READ,
    OP_PROGRAM, OP_COPY_PROGRAM, OP_ERASE, OP_RAND_OUT, OP_RAND_IN
  } op_t;
  // kind of a single bus cycle
  typedef enum logic [1:0] {CYC_CMD, CYC_ADDR, CYC_WRITE, CYC_READ} cyc_t;
endpackage

// *** hw/nand_host_seq.sv ***
// Purpose: host sequencer issuing flash command, address and data cycles
// Assumes: flash ready/busy pin sampled synchronously, pulled up outside
// Notes:   one operation at a time; data bytes stream through handshakes
// Operation
// (R1) Device floats io when deselected; host drives io only on write cycles.
// (R2) Command byte latched on write strobe rising edge with command latch high.
// (R3) Address byte latched on write strobe rising edge with address latch high.
// (R4) Device stays busy during program or erase even if deselected.
// (R5) Each read strobe falling edge gives next byte, column advances.
// (R6) Write protect low blocks program and erase.
// (R7) Ready/busy low while program, erase or page read runs.
// (R8) Ready/busy is open drain, valid while deselected.
// (R9) Full address is five cycles: two column, three row, low first.
// (R10) Unused high bits of cycle two and cycle five driven low.
// (R11) Device ignores surplus address cycles.
// (R12) Read and program take five address cycles; erase takes three row cycles.
// (R13) Twelve-bit column picks start byte in page register.
// (R14) Page has 2112 columns, spare from 2048; 131072 pages.
// (R15) Read and program by page, erase by block; 2048 blocks.
// (R16) Page read 00h then 30h; copy-back read 00h then 35h.
// (R17) Program 80h then 10h; erase 60h then D0h; confirm starts.
// (R18) Copy-back program 85h, address, 10h, no external data.
// (R19) Reset, status, read ID single cycle; only reset/status while busy.
// (R20) Random data in 85h and out 05h/E0h stay within page.
// (R21) Copy-check status read used only within copy-back.
// (R22) After two-plane first confirm only status or reset until second setup.
// (R23) Host never issues undefined command bytes.
// (R24) Host waits for ready before other than status or reset.
module nand_host_seq #(
  parameter int BYTE_COUNT_W = 12
) (
  input  wire logic                    ref_clk,
  input  wire logic                    rst_n,
  // user request
  input  wire logic                    op_valid,
  output logic                         op_ready,
  input  wire nand_host_pkg::op_t      op_kind,
  input  wire logic [28:0]             op_addr,
  input  wire logic [BYTE_COUNT_W-1:0] op_len,
  input  wire logic                    write_enable,
  // data towards the flash
  input  wire logic                    wr_valid,
  output logic                         wr_ready,
  input  wire logic [7:0]              wr_data,
  // data from the flash
  output logic                         rd_valid,
  output logic [7:0]                   rd_data,
  output logic                         op_done,
  output logic                         busy_seen,
  // flash pins
  output logic                         chip_select_n,
  output logic                         cmd_latch,
  output logic                         addr_latch,
  output logic                         write_strobe_n,
  output logic                         output_strobe_n,
  output logic                         write_protect_n,
  output logic [7:0]                   io_out,
  output logic                         io_oe,
  input  wire logic [7:0]              io_in,
  input  wire logic                    ready_busy
);
  typedef enum logic [2:0] {S_IDLE, S_CMD1, S_ADDR, S_DATA, S_CMD2, S_WAIT} seq_t;
  seq_t                    st_q;
  nand_host_pkg::op_t      op_q;
  logic [28:0]             addr_q;
  logic [2:0]              acnt_q;
  logic [BYTE_COUNT_W-1:0] left_q;
  logic                    pend_q;
  logic [1:0]              rb_sync_q;
  nand_cycle_if            cyc ();

  // ==========================================================
  // request decode
  function automatic logic [7:0] setup_code(input nand_host_pkg::op_t k);
    case (k)
      nand_host_pkg::OP_RESET:        setup_code = nand_host_pkg::CMD_RESET;
      nand_host_pkg::OP_STATUS:       setup_code = nand_host_pkg::CMD_STATUS;
      nand_host_pkg::OP_COPY_STATUS:  setup_code = nand_host_pkg::CMD_COPY_STATUS; // [R21]
      nand_host_pkg::OP_READ_ID:      setup_code = nand_host_pkg::CMD_READ_ID;
      nand_host_pkg::OP_PROGRAM:      setup_code = nand_host_pkg::CMD_PROG_SETUP;
      nand_host_pkg::OP_COPY_PROGRAM: setup_code = nand_host_pkg::CMD_COPY_PROG;
      nand_host_pkg::OP_RAND_IN:      setup_code = nand_host_pkg::CMD_COPY_PROG;
      nand_host_pkg::OP_ERASE:        setup_code = nand_host_pkg::CMD_ERASE_SETUP;
      nand_host_pkg::OP_RAND_OUT:     setup_code = nand_host_pkg::CMD_RAND_OUT;
      default:                        setup_code = nand_host_pkg::CMD_READ_SETUP;
    endcase
  endfunction

  // confirm code; 8'h00 marks an operation without one; no two-plane codes [R22]
  function automatic logic [7:0] confirm_code(input nand_host_pkg::op_t k);
    case (k)
      nand_host_pkg::OP_READ:         confirm_code = nand_host_pkg::CMD_READ_CONFIRM;
      nand_host_pkg::OP_COPY_READ:    confirm_code = nand_host_pkg::CMD_COPY_READ_CNF;
      nand_host_pkg::OP_PROGRAM,
      nand_host_pkg::OP_COPY_PROGRAM: confirm_code = nand_host_pkg::CMD_PROG_CONFIRM;
      nand_host_pkg::OP_ERASE:        confirm_code = nand_host_pkg::CMD_ERASE_CONFIRM;
      nand_host_pkg::OP_RAND_OUT:     confirm_code = nand_host_pkg::CMD_RAND_OUT_CNF;
      default:                        confirm_code = 8'h00;
    endcase
  endfunction

  // address cycles used by each operation
  function automatic logic [2:0] addr_count(input nand_host_pkg::op_t k);
    case (k)
      nand_host_pkg::OP_READ, nand_host_pkg::OP_COPY_READ, nand_host_pkg::OP_PROGRAM,
      nand_host_pkg::OP_COPY_PROGRAM: addr_count = 3'(nand_host_pkg::ADDR_CYCLES); // [R12]
      nand_host_pkg::OP_ERASE:        addr_count = 3'(nand_host_pkg::ROW_CYCLES);  // [R12]
      nand_host_pkg::OP_RAND_OUT,
      nand_host_pkg::OP_RAND_IN:      addr_count = 3'd2; // column only [R20]
      nand_host_pkg::OP_READ_ID:      addr_count = 3'd1;
      default:                        addr_count = 3'd0;
    endcase
  endfunction

  wire       rb_ready   = rb_sync_q[1];
  wire       always_ok  = (op_kind == nand_host_pkg::OP_RESET) ||
                          (op_kind == nand_host_pkg::OP_STATUS) ||
                          (op_kind == nand_host_pkg::OP_COPY_STATUS);
  wire       op_take    = op_valid && op_ready;
  wire       is_write_op = (op_q == nand_host_pkg::OP_PROGRAM) ||
                           (op_q == nand_host_pkg::OP_RAND_IN);
  wire       has_data   = (op_q == nand_host_pkg::OP_STATUS) ||
                          (op_q == nand_host_pkg::OP_COPY_STATUS) ||
                          (op_q == nand_host_pkg::OP_READ_ID) ||
                          (op_q == nand_host_pkg::OP_RAND_OUT) || is_write_op;
  wire       has_cnf    = (confirm_code(op_q) != 8'h00);
  wire       acc        = cyc.valid && cyc.ready;
  wire       row_only   = (op_q == nand_host_pkg::OP_ERASE);
  wire [2:0] acyc       = row_only ? acnt_q + 3'd2 : acnt_q;
  wire [7:0] addr_byte;
  wire       data_first = (op_q == nand_host_pkg::OP_RAND_OUT);

  // five-cycle layout, unused high bits forced low
  assign addr_byte = (acyc == 3'd0) ? addr_q[7:0] :                 // [R9]
                     (acyc == 3'd1) ? {4'h0, addr_q[11:8]} :        // [R10] [R13]
                     (acyc == 3'd2) ? addr_q[19:12] :
                     (acyc == 3'd3) ? addr_q[27:20] :
                                      {7'h00, addr_q[28]};          // [R10]

  // requests other than reset and the two status reads wait for ready
  assign op_ready  = (st_q == S_IDLE) && (rb_ready || always_ok);   // [R24] [R19]
  assign wr_ready  = (st_q == S_DATA) && is_write_op && cyc.ready && !pend_q;
  assign cyc.valid = !pend_q && ((st_q == S_CMD1) || (st_q == S_ADDR) || (st_q == S_CMD2) ||
                     ((st_q == S_DATA) && (!is_write_op || wr_valid)));
  assign cyc.kind  = (st_q == S_ADDR) ? nand_host_pkg::CYC_ADDR :
                     (st_q == S_DATA) ? (is_write_op ? nand_host_pkg::CYC_WRITE
                                                     : nand_host_pkg::CYC_READ) :
                                        nand_host_pkg::CYC_CMD;
  assign cyc.wdata = (st_q == S_CMD1) ? setup_code(op_q) :         // [R16] [R17] [R18]
                     (st_q == S_CMD2) ? confirm_code(op_q) :       // [R17] [R23]
                     (st_q == S_ADDR) ? addr_byte : wr_data;

  // ==========================================================
  // ready/busy synchroniser; open drain pulled high outside
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) rb_sync_q <= 2'b00;
    else rb_sync_q <= {rb_sync_q[0], ready_busy}; // [R8]
  end

  // pin levels owned by the sequencer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      chip_select_n <= 1'b1;
      write_protect_n <= 1'b0;
    end else begin
      chip_select_n <= (st_q == S_IDLE) && !op_take;  // deselect between ops [R4]
      write_protect_n <= write_enable;                // [R6]
    end
  end

  // ==========================================================
  // operation sequencer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= S_IDLE;
      op_q <= nand_host_pkg::OP_RESET;
      addr_q <= 29'h0;
      acnt_q <= 3'd0;
      left_q <= '0;
      pend_q <= 1'b0;
      op_done <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= 8'h00;
      busy_seen <= 1'b0;
    end else begin
      op_done <= 1'b0;
      rd_valid <= 1'b0;
      if (cyc.done) pend_q <= 1'b0;
      if (acc) pend_q <= 1'b1;
      case (st_q)
        S_IDLE: if (op_take) begin
          op_q <= op_kind;
          addr_q <= op_addr;
          left_q <= op_len;
          acnt_q <= 3'd0;
          busy_seen <= 1'b0;
          st_q <= S_CMD1;
        end
        S_CMD1: if (cyc.done) begin
          if (addr_count(op_q) != 3'd0) st_q <= S_ADDR;
          else if (has_data) st_q <= S_DATA;
          else st_q <= S_WAIT;
        end
        S_ADDR: if (cyc.done) begin
          acnt_q <= acnt_q + 3'd1;
          if (acnt_q + 3'd1 == addr_count(op_q)) // no surplus cycles sent [R11]
            st_q <= (data_first || !has_data) ? (has_cnf ? S_CMD2 : S_WAIT) : S_DATA;
        end
        S_DATA: if (cyc.done) begin
          rd_valid <= !is_write_op;
          rd_data <= cyc.rdata; // [R5]
          left_q <= left_q - 1'b1;
          if (left_q <= 1) st_q <= has_cnf && !data_first ? S_CMD2 : S_WAIT;
        end
        S_CMD2: if (cyc.done) st_q <= (data_first && left_q != 0) ? S_DATA : S_WAIT;
        S_WAIT: begin
          if (!rb_ready) busy_seen <= 1'b1; // [R7]
          if (rb_ready && !cyc.done && !pend_q) begin
            op_done <= 1'b1;
            st_q <= S_IDLE;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  nand_strobe_engine u_engine (
    .ref_clk         (ref_clk),
    .rst_n           (rst_n),
    .cyc             (cyc.engine),
    .cmd_latch       (cmd_latch),
    .addr_latch      (addr_latch),
    .write_strobe_n  (write_strobe_n),
    .output_strobe_n (output_strobe_n),
    .io_out          (io_out),
    .io_oe           (io_oe),
    .io_in           (io_in)
  );

  // ==========================================================
  chk_io_oe_write: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R1]
    io_oe |-> output_strobe_n) else $error("io driven while reading");
  chk_busy_gate: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R24]
    (op_ready && !rb_ready) |-> always_ok) else $error("busy accepts bad op");
  chk_addr_pad: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R10]
    (cyc.valid && st_q == S_ADDR && acyc == 3'd4) |-> cyc.wdata[7:1] == 7'h00)
    else $error("fifth address cycle high bits set");
  chk_addr_count: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R12]
    (st_q == S_ADDR) |-> acnt_q < addr_count(op_q)) else $error("extra address cycle");
  chk_wp_follow: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R6]
    !write_enable |=> !write_protect_n) else $error("protect not applied");
  chk_cs_active: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R2]
    (!write_strobe_n || !output_strobe_n) |-> !chip_select_n)
    else $error("strobe while deselected");
  chk_cmd_defined: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R23]
    (cyc.valid && st_q == S_CMD2) |-> cyc.wdata != 8'h00) else $error("empty confirm");
  chk_done_ready: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R7]
    op_done |-> $past(rb_ready)) else $error("done while busy");
endmodule

// *** hw/nand_strobe_engine.sv ***
// Purpose: drives one write or read strobe cycle on the flash pins
// Assumes: strobe phases of STROBE_CYCLES clocks each
// Notes:   bytes latch in the flash on the rising edge of the write strobe
module nand_strobe_engine (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  nand_cycle_if.engine    cyc,
  output logic            cmd_latch,
  output logic            addr_latch,
  output logic            write_strobe_n,
  output logic            output_strobe_n,
  output logic [7:0]      io_out,
  output logic            io_oe,
  input  wire logic [7:0] io_in
);
  typedef enum logic [1:0] {E_IDLE, E_LOW, E_HIGH} eng_t;
  eng_t       st_q;
  logic [3:0] cnt_q;
  nand_host_pkg::cyc_t kind_q;
  logic [7:0] rdata_q;
  logic       done_q;
  wire        phase_end = (cnt_q == nand_host_pkg::STROBE_LAST);
  wire        is_read   = (kind_q == nand_host_pkg::CYC_READ);

  assign cyc.ready = (st_q == E_IDLE);
  assign cyc.done  = done_q;
  assign cyc.rdata = rdata_q;

  // ==========================================================
  // strobe sequencing: low phase then high phase
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= E_IDLE;
      cnt_q <= 4'h0;
      kind_q <= nand_host_pkg::CYC_CMD;
      io_out <= 8'h00;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      cnt_q <= phase_end ? 4'h0 : cnt_q + 4'h1;
      case (st_q)
        E_IDLE: begin
          cnt_q <= 4'h0;
          if (cyc.valid) begin
            st_q <= E_LOW;
            kind_q <= cyc.kind;
            io_out <= cyc.wdata;
          end
        end
        E_LOW: if (phase_end) st_q <= E_HIGH;
        E_HIGH: if (phase_end) begin
          st_q <= E_IDLE;
          done_q <= 1'b1;
        end
        default: st_q <= E_IDLE;
      endcase
    end
  end

  // read byte sampled at end of the low phase of the read strobe
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) rdata_q <= 8'h00;
    else if (st_q == E_LOW && phase_end && is_read) rdata_q <= io_in; // [R5]
  end

  // latch selects held across the whole cycle so the rising edge sees them
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_latch <= 1'b0;
      addr_latch <= 1'b0;
      write_strobe_n <= 1'b1;
      output_strobe_n <= 1'b1;
      io_oe <= 1'b0;
    end else begin
      cmd_latch <= (st_q != E_IDLE) && kind_q == nand_host_pkg::CYC_CMD;   // [R2]
      addr_latch <= (st_q != E_IDLE) && kind_q == nand_host_pkg::CYC_ADDR; // [R3]
      write_strobe_n <= !(st_q == E_LOW && !is_read);
      output_strobe_n <= !(st_q == E_LOW && is_read); // [R5]
      io_oe <= (st_q != E_IDLE) && !is_read;
    end
  end

  chk_latch_exclusive: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R2]
    !(cmd_latch && addr_latch)) else $error("both latch selects high");
  chk_no_read_drive: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R5]
    !output_strobe_n |-> !io_oe) else $error("host drives io during read strobe");
endmodule

// *** verif/nand_flash_model.sv ***
// Purpose: behavioural flash device facing the host sequencer pins
// Assumes: ready_busy pulled up outside, io resolved by the bench
// Notes:   erased bytes read FFh; status and id bytes are arbitrary
module nand_flash_model #(
  parameter logic [7:0] STATUS_BYTE = 8'hC0, // arbitrary value
  parameter logic [7:0] ID_BASE     = 8'h3C, // arbitrary value
  parameter int         BUSY_NS     = 1000
) (
  input  wire logic       chip_select_n,
  input  wire logic       cmd_latch,
  input  wire logic       addr_latch,
  input  wire logic       write_strobe_n,
  input  wire logic       output_strobe_n,
  input  wire logic       write_protect_n,
  input  wire logic [7:0] io_out,
  output logic      [7:0] io_dev,
  output logic            rb_low
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem   [int];
  logic [7:0] pg_wr [int];
  logic [7:0] mode  = 8'hFF;
  logic [7:0] out_q = 8'h00;
  int         col   = 0;
  int         row   = 0;
  int         acnt  = 0;
  int         pg_row = -1;
  initial rb_low = 1'b0;
  // ==========================================================
  // read path: released bus shows the inverse of the last byte
  assign io_dev = (!output_strobe_n && !chip_select_n) ? out_q : ~out_q;
  function automatic logic [7:0] pick(int c);
    if (mode == 8'h70 || mode == 8'h7B) return STATUS_BYTE;
    if (mode == 8'h90) return ID_BASE + 8'(c);
    if (pg_wr.exists(c)) return pg_wr[c];
    return mem.exists(pg_row * 4096 + c) ? mem[pg_row * 4096 + c] : 8'hFF;
  endfunction
  // page register to array, copy-back keeps the source page
  task automatic commit();
    for (int c = 0; c < 2112; c++) mem[row * 4096 + c] = pick(c);
  endtask
  // whole block of 64 pages back to erased
  task automatic wipe();
    for (int k = (row / 64) * 262144; k < (row / 64 + 1) * 262144; k++) mem.delete(k);
  endtask
  // busy span on the open-drain pin, whatever chip select does
  task automatic go_busy();
    rb_low <= 1'b1;
    rb_low <= #(BUSY_NS) 1'b0;
  endtask
  // each falling read strobe shows the next byte
  always @(negedge output_strobe_n) begin
    if (!chip_select_n) begin
      out_q = pick(col);
      col++;
    end
  end
  // command, address and data capture on rising write strobe
  always @(posedge write_strobe_n) begin
    if (chip_select_n) begin // deselected: strobe ignored
    end else if (cmd_latch) begin
      if (!rb_low || io_out == 8'hFF || io_out == 8'h70 || io_out == 8'h7B) begin
        mode = io_out;
        acnt = (io_out == 8'h60) ? 2 : 0;
        if (io_out == 8'h80) begin
          pg_wr.delete();
          pg_row = -1;
        end
        if (io_out == 8'h30 || io_out == 8'h35) begin
          pg_wr.delete();
          pg_row = row;
          go_busy();
        end
        if (io_out == 8'h10 && write_protect_n) begin
          commit();
          go_busy();
        end
        if (io_out == 8'hD0 && write_protect_n) begin
          wipe();
          go_busy();
        end
      end
    end else if (addr_latch) begin
      case (acnt)
        0: col = int'(io_out);
        1: col = col + 256 * int'(io_out[3:0]);
        2: row = int'(io_out);
        3: row = row + 256 * int'(io_out);
        4: row = row + 65536 * int'(io_out[0]);
        default: acnt = acnt;
      endcase
      acnt++;
    end else begin
      pg_wr[col] = io_out;
      col++;
    end
  end
endmodule

// *** verif/nand_host_seq_test.sv ***
// Purpose: self-checking bench for the flash host sequencer
// Assumes: behavioural flash model on the far side of the pins
// Notes:   pins monitored on write strobe, reads compared in order
module nand_host_seq_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] STATUS_VAL = 8'hC0; // arbitrary value
  localparam logic [7:0] ID_VAL     = 8'h3C; // arbitrary value
  // first code, second code (00h none), address byte range per op kind
  localparam logic [7:0] C1 [11] = '{8'hFF, 8'h70, 8'h7B, 8'h90, 8'h00, 8'h00,
                                     8'h80, 8'h85, 8'h60, 8'h05, 8'h85};
  localparam logic [7:0] C2 [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h30, 8'h35,
                                     8'h10, 8'h10, 8'hD0, 8'hE0, 8'h00};
  localparam int         LO [11] = '{0, 0, 0, 0, 0, 0, 0, 0, 2, 0, 0};
  localparam int         HI [11] = '{0, 0, 0, 1, 5, 5, 5, 5, 5, 2, 2};
  logic ref_clk, rst_n, op_valid, op_ready, write_enable, wr_valid, wr_ready;
  logic rd_valid, op_done, busy_seen, chip_select_n, cmd_latch, addr_latch;
  logic write_strobe_n, output_strobe_n, write_protect_n, io_oe, ready_busy, rb_low;
  nand_host_pkg::op_t op_kind;
  logic [28:0] op_addr;
  logic [11:0] op_len;
  logic [7:0]  wr_data, rd_data, io_out, io_in, io_dev;
  logic [7:0]  exp_lat [$], exp_rd [$], wr_q [$];
  int          n_mismatch = 0, total_checks = 0;
  nand_host_seq nand_host_seq_i (.ref_clk(ref_clk), .rst_n(rst_n), .op_valid(op_valid),
    .op_ready(op_ready), .op_kind(op_kind), .op_addr(op_addr), .op_len(op_len),
    .write_enable(write_enable), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_data(wr_data), .rd_valid(rd_valid), .rd_data(rd_data), .op_done(op_done),
    .busy_seen(busy_seen), .chip_select_n(chip_select_n), .cmd_latch(cmd_latch),
    .addr_latch(addr_latch), .write_strobe_n(write_strobe_n),
    .output_strobe_n(output_strobe_n), .write_protect_n(write_protect_n),
    .io_out(io_out), .io_oe(io_oe), .io_in(io_in), .ready_busy(ready_busy));
  nand_flash_model #(.STATUS_BYTE(STATUS_VAL), .ID_BASE(ID_VAL)) nand_flash_model_i (
    .chip_select_n(chip_select_n), .cmd_latch(cmd_latch), .addr_latch(addr_latch),
    .write_strobe_n(write_strobe_n), .output_strobe_n(output_strobe_n),
    .write_protect_n(write_protect_n), .io_out(io_out), .io_dev(io_dev), .rb_low(rb_low));
  // ==========================================================
  // shared io bus, ready_busy pulled up
  assign io_in      = io_oe ? io_out : io_dev;
  assign ready_busy = rb_low ? 1'b0 : 1'b1;
  always #12.5 ref_clk = ~ref_clk;
  task automatic cmp_byte(string what, logic [7:0] exp, logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp_flag(string what, logic exp, logic got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic stop_test();
    if (n_mismatch == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // latched command and address bytes in order
  always @(posedge write_strobe_n) begin
    if (!chip_select_n && (cmd_latch || addr_latch)) begin
      cmp_byte("latched byte", exp_lat.size() ? exp_lat.pop_front() : 8'hXX, io_out);
    end
  end
  // read bytes against the oldest note
  always @(posedge ref_clk) begin
    if (rd_valid === 1'b1) begin
      cmp_byte("read byte", exp_rd.size() ? exp_rd.pop_front() : 8'hXX, rd_data);
    end
  end
  // write data feeder, head of queue held until taken
  always @(posedge ref_clk) begin
    if (wr_valid === 1'b1 && wr_ready === 1'b1) void'(wr_q.pop_front());
    wr_valid <= (wr_q.size() > 0);
    wr_data  <= (wr_q.size() > 0) ? wr_q[0] : 8'h00;
  end
  task automatic run_op(nand_host_pkg::op_t k, logic [16:0] r, logic [11:0] c,
                        logic [11:0] n, logic we);
    logic [28:0] a;
    logic [7:0]  ab [5];
    int          t;
    a  = {r, c};
    ab = '{a[7:0], {4'h0, a[11:8]}, a[19:12], a[27:20], {7'h00, a[28]}};
    exp_lat.push_back(C1[k]);
    for (int i = LO[k]; i < HI[k]; i++) exp_lat.push_back(ab[i]);
    if (C2[k] != 8'h00) exp_lat.push_back(C2[k]);
    write_enable <= we;
    @(posedge ref_clk);
    op_valid <= 1'b1;
    op_kind  <= k;
    op_addr  <= a;
    op_len   <= n;
    t = 0;
    do begin
      @(posedge ref_clk);
      t++;
    end while (op_ready !== 1'b1 && t < 200);
    op_valid <= 1'b0;
    do begin
      @(posedge ref_clk);
      t++;
    end while (op_done !== 1'b1 && t < 20000);
    @(posedge ref_clk);
    if (t >= 20000) begin
      n_mismatch++;
      stop_test();
    end
    cmp_flag("all bytes seen", 1'b1, exp_rd.size() == 0 && exp_lat.size() == 0);
    if (k >= nand_host_pkg::OP_READ && k <= nand_host_pkg::OP_ERASE) begin
      cmp_flag("busy_seen", we || k < nand_host_pkg::OP_PROGRAM, busy_seen);
    end
  endtask
  initial begin
    logic [7:0]  d [4];
    logic [16:0] r1;
    ref_clk = 1'b0;
    rst_n = 1'b0;
    op_valid = 1'b0;
    op_kind = nand_host_pkg::OP_RESET;
    op_addr = '0;
    op_len = '0;
    write_enable = 1'b0;
    wr_valid = 1'b0;
    wr_data = 8'h00;
    void'($urandom(32'h48438C34));
    r1 = 17'($urandom);
    foreach (d[i]) d[i] = 8'($urandom);
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    run_op(nand_host_pkg::OP_RESET, 0, 0, 0, 1);
    exp_rd.push_back(STATUS_VAL);
    run_op(nand_host_pkg::OP_STATUS, 0, 0, 1, 1);
    for (int i = 0; i < 4; i++) exp_rd.push_back(ID_VAL + 8'(i));
    run_op(nand_host_pkg::OP_READ_ID, 0, 0, 4, 1);
    // spare area end: columns 2108 to 2111
    foreach (d[i]) wr_q.push_back(d[i]);
    run_op(nand_host_pkg::OP_PROGRAM, r1, 12'h83C, 4, 1);
    run_op(nand_host_pkg::OP_READ, r1, 12'h83C, 0, 1);
    foreach (d[i]) exp_rd.push_back(d[i]);
    run_op(nand_host_pkg::OP_RAND_OUT, 0, 12'h83C, 4, 1);
    exp_rd.push_back(d[2]);
    exp_rd.push_back(d[3]);
    run_op(nand_host_pkg::OP_RAND_OUT, 0, 12'h83E, 2, 1);
    // copy-back with one byte replaced in the page register
    run_op(nand_host_pkg::OP_COPY_READ, r1, 12'h83C, 0, 1);
    wr_q.push_back(~d[1]);
    run_op(nand_host_pkg::OP_RAND_IN, 0, 12'h83D, 1, 1);
    run_op(nand_host_pkg::OP_COPY_PROGRAM, r1 ^ 17'h00040, 0, 0, 1);
    run_op(nand_host_pkg::OP_READ, r1 ^ 17'h00040, 12'h83C, 0, 1);
    exp_rd = '{d[0], ~d[1], d[2], d[3]};
    run_op(nand_host_pkg::OP_RAND_OUT, 0, 12'h83C, 4, 1);
    exp_rd.push_back(STATUS_VAL);
    run_op(nand_host_pkg::OP_COPY_STATUS, 0, 0, 1, 1);
    // protected program leaves the page erased
    wr_q = '{d[0], d[1]};
    run_op(nand_host_pkg::OP_PROGRAM, r1 ^ 17'h10000, 12'h83C, 2, 0);
    run_op(nand_host_pkg::OP_READ, r1 ^ 17'h10000, 12'h83C, 0, 1);
    exp_rd = '{8'hFF, 8'hFF};
    run_op(nand_host_pkg::OP_RAND_OUT, 0, 12'h83C, 2, 1);
    run_op(nand_host_pkg::OP_ERASE, r1, 0, 0, 1);
    run_op(nand_host_pkg::OP_READ, r1, 12'h83C, 0, 1);
    exp_rd = '{8'hFF, 8'hFF, 8'hFF, 8'hFF};
    run_op(nand_host_pkg::OP_RAND_OUT, 0, 12'h83C, 4, 1);
    stop_test();
  end
endmodule
